//--- hw/mcilk_cfg.svh
`ifndef MCILK_CFG_SVH
`define MCILK_CFG_SVH

// ****************************************
// interface area geometry
// ****************************************
`define MCILK_TASKS 4
`define MCILK_AXES 4
`define MCILK_WORD_W 16
`define MCILK_NUM_OPS 11
`define MCILK_RST_WORD 16'h0000

// ****************************************
// word offsets: task k number at first+2k, control right after
// ****************************************
`define MCILK_OFS_NUM0 4'h2
`define MCILK_OFS_CTRL0 4'h3
`define MCILK_OFS_LAST 4'h9

// ****************************************
// task control word bits
// ****************************************
`define MCILK_BIT_MODE 1
`define MCILK_BIT_CYCLE 2
`define MCILK_BIT_READ 7

// ****************************************
// axis command word bits
// ****************************************
`define MCILK_BIT_DECEL 0
`define MCILK_BIT_ORIGIN 1
`define MCILK_BIT_REFRET 2
`define MCILK_BIT_JOG 3
`define MCILK_BIT_ERRRST 4
`define MCILK_BIT_FORCED 5
`define MCILK_BIT_ABSINIT 6
`define MCILK_BIT_HANDWHEEL 8
`define MCILK_BIT_LOCK 9
`define MCILK_BIT_RELEASE 10

`endif

//--- hw/mcilk_pkg.sv
`include "mcilk_cfg.svh"

package mcilk_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_DECEL,
        OP_ORIGIN,
        OP_REFRET,
        OP_JOG,
        OP_ERRRST,
        OP_FORCED,
        OP_ABSINIT,
        OP_HANDWHEEL,
        OP_LOCK,
        OP_RELEASE,
        OP_PRESET
    } mcilk_op_t;

    typedef struct packed {
        logic opDone;
        logic errRstDone;
        logic relDone;
    } mcilk_axis_done_t;

    typedef struct packed {
        logic busy;
        logic start;
        logic abort;
        mcilk_op_t startOp;
    } mcilk_axis_stat_t;

    typedef struct packed {
        logic [`MCILK_WORD_W-1:0] prevWord;
        mcilk_op_t op;
        logic errRstRun;
        logic relRun;
        mcilk_axis_stat_t stat;
    } mcilk_axis_state_t;

    typedef struct packed {
        logic [`MCILK_TASKS-1:0][`MCILK_WORD_W-1:0] numWord;
        logic [`MCILK_TASKS-1:0][`MCILK_WORD_W-1:0] ctrlWord;
        logic [`MCILK_TASKS-1:0][`MCILK_WORD_W-1:0] prevCtrl;
        logic [`MCILK_TASKS-1:0][`MCILK_WORD_W-1:0] progNum;
        logic [`MCILK_TASKS-1:0] run;
        logic [`MCILK_TASKS-1:0] done;
        logic [`MCILK_TASKS-1:0] start;
        logic [`MCILK_WORD_W-1:0] rdData;
    } mcilk_top_state_t;

endpackage

//--- hw/mcilk_axis.sv
`timescale 1ns/1ns
`include "mcilk_cfg.svh"

module mcilk_axis (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    // sampled command word
    input wire logic scan,
    input wire logic [`MCILK_WORD_W-1:0] cmdWord,
    input wire logic autoMode,
    input wire logic modeEdge,
    input wire logic presetReq,
    // completions from the motion engine
    input wire mcilk_pkg::mcilk_axis_done_t done,
    // status
    output mcilk_pkg::mcilk_axis_stat_t stat
);

    localparam mcilk_pkg::mcilk_op_t PRIO [`MCILK_NUM_OPS] = '{
        mcilk_pkg::OP_DECEL, mcilk_pkg::OP_ERRRST, mcilk_pkg::OP_ORIGIN,
        mcilk_pkg::OP_REFRET, mcilk_pkg::OP_JOG, mcilk_pkg::OP_FORCED,
        mcilk_pkg::OP_ABSINIT, mcilk_pkg::OP_HANDWHEEL, mcilk_pkg::OP_LOCK,
        mcilk_pkg::OP_RELEASE, mcilk_pkg::OP_PRESET};

    mcilk_pkg::mcilk_axis_state_t q;
    mcilk_pkg::mcilk_axis_state_t d;

    function automatic logic isCont(input mcilk_pkg::mcilk_op_t o);
        return o inside {mcilk_pkg::OP_ORIGIN, mcilk_pkg::OP_REFRET,
                         mcilk_pkg::OP_JOG, mcilk_pkg::OP_HANDWHEEL};
    endfunction

    function automatic logic [3:0] bitOf(input mcilk_pkg::mcilk_op_t o);
        unique case (o)
            mcilk_pkg::OP_DECEL: return 4'(`MCILK_BIT_DECEL);
            mcilk_pkg::OP_ORIGIN: return 4'(`MCILK_BIT_ORIGIN);
            mcilk_pkg::OP_REFRET: return 4'(`MCILK_BIT_REFRET);
            mcilk_pkg::OP_JOG: return 4'(`MCILK_BIT_JOG);
            mcilk_pkg::OP_ERRRST: return 4'(`MCILK_BIT_ERRRST);
            mcilk_pkg::OP_FORCED: return 4'(`MCILK_BIT_FORCED);
            mcilk_pkg::OP_ABSINIT: return 4'(`MCILK_BIT_ABSINIT);
            mcilk_pkg::OP_HANDWHEEL: return 4'(`MCILK_BIT_HANDWHEEL);
            mcilk_pkg::OP_LOCK: return 4'(`MCILK_BIT_LOCK);
            mcilk_pkg::OP_RELEASE: return 4'(`MCILK_BIT_RELEASE);
            default: return 4'h0;
        endcase
    endfunction

    // acceptance matrix against what is already executing
    function automatic logic allowed(input mcilk_pkg::mcilk_axis_state_t s,
                                     input logic decelHeld, input logic autoM,
                                     input mcilk_pkg::mcilk_op_t r);
        logic ok;
        logic keep;
        ok = 1'b0;
        keep = r inside {mcilk_pkg::OP_ERRRST, mcilk_pkg::OP_RELEASE};
        unique case (s.op)
            mcilk_pkg::OP_NONE: ok = 1'b1;
            mcilk_pkg::OP_ORIGIN, mcilk_pkg::OP_REFRET, mcilk_pkg::OP_JOG,
            mcilk_pkg::OP_HANDWHEEL: ok = keep || r == mcilk_pkg::OP_DECEL;
            mcilk_pkg::OP_DECEL, mcilk_pkg::OP_ABSINIT, mcilk_pkg::OP_LOCK,
            mcilk_pkg::OP_PRESET: ok = keep;
            mcilk_pkg::OP_FORCED: ok = r == mcilk_pkg::OP_RELEASE;
            default: ok = 1'b0;
        endcase
        if (s.errRstRun && !(keep || r == mcilk_pkg::OP_DECEL)) begin
            ok = 1'b0;
        end
        if (s.relRun && r != mcilk_pkg::OP_ERRRST) begin
            ok = 1'b0;
        end
        // a held stop still lets its own rising edge through
        if (decelHeld && !(keep || r == mcilk_pkg::OP_DECEL)) begin
            ok = 1'b0;
        end
        if (autoM && !keep) begin
            ok = 1'b0;
        end
        if (r == mcilk_pkg::OP_PRESET && s.stat.busy) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    always_comb begin
        mcilk_pkg::mcilk_op_t r;
        logic [`MCILK_WORD_W-1:0] rise;
        logic picked;
        logic req;
        r = mcilk_pkg::OP_NONE;
        rise = '0;
        picked = 1'b0;
        req = 1'b0;
        d = q;
        d.stat.start = 1'b0;
        d.stat.abort = 1'b0;
        if (done.opDone) begin
            d.op = mcilk_pkg::OP_NONE;
        end
        if (done.errRstDone) begin
            d.errRstRun = 1'b0;
        end
        if (done.relDone) begin
            d.relRun = 1'b0;
        end
        if (scan) begin
            rise = cmdWord & ~q.prevWord;
            d.prevWord = cmdWord;
            if (isCont(q.op) && !cmdWord[bitOf(q.op)]) begin
                d.op = mcilk_pkg::OP_NONE;
                d.stat.abort = 1'b1;
            end else if (isCont(q.op) && modeEdge) begin
                d.op = mcilk_pkg::OP_DECEL;
                d.stat.abort = 1'b1;
            end
            for (int i = 0; i < `MCILK_NUM_OPS; i++) begin
                r = PRIO[i];
                req = (r == mcilk_pkg::OP_PRESET) ? presetReq : rise[bitOf(r)];
                if (!picked && req && allowed(q, cmdWord[`MCILK_BIT_DECEL], autoMode, r)) begin
                    picked = 1'b1;
                    if (r == mcilk_pkg::OP_DECEL) begin
                        // stop with nothing to stop is a no-op
                        if (isCont(q.op) || q.errRstRun) begin
                            d.op = mcilk_pkg::OP_DECEL;
                            d.stat.abort = isCont(q.op);
                            d.stat.start = 1'b1;
                            d.stat.startOp = r;
                        end
                    end else begin
                        if (r == mcilk_pkg::OP_ERRRST) begin
                            d.errRstRun = 1'b1;
                        end else if (r == mcilk_pkg::OP_RELEASE) begin
                            d.relRun = 1'b1;
                        end else begin
                            d.op = r;
                        end
                        d.stat.start = 1'b1;
                        d.stat.startOp = r;
                    end
                end
            end
        end
        d.stat.busy = d.op != mcilk_pkg::OP_NONE || d.errRstRun || d.relRun;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end

    assign stat = q.stat;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    jogDropAbort_a: assert property (en && scan && q.op == mcilk_pkg::OP_JOG
        && !cmdWord[`MCILK_BIT_JOG] |=> stat.abort && q.op != mcilk_pkg::OP_JOG)
        else $error("jog not aborted when its bit fell");
    forcedOnlyRel_a: assert property (en && q.op == mcilk_pkg::OP_FORCED
        ##1 stat.start |-> stat.startOp == mcilk_pkg::OP_RELEASE)
        else $error("command other than release accepted during forced set");
    presetIdle_a: assert property (en && q.stat.busy ##1 stat.start
        |-> stat.startOp != mcilk_pkg::OP_PRESET)
        else $error("preset accepted while busy");
    autoManual_a: assert property (en && scan && autoMode ##1 stat.start
        |-> stat.startOp inside {mcilk_pkg::OP_ERRRST, mcilk_pkg::OP_RELEASE})
        else $error("manual command accepted in automatic mode");
    busyDrop_a: assert property (en && done.opDone && !q.errRstRun
        && !q.relRun && !presetReq && !modeEdge && (!scan || cmdWord == q.prevWord)
        |=> !stat.busy)
        else $error("busy stayed high after completion");
    decelNoop_a: assert property (en && scan && q.op == mcilk_pkg::OP_NONE
        && !q.errRstRun && !q.relRun |=> !(stat.start && stat.startOp == mcilk_pkg::OP_DECEL))
        else $error("idle stop changed state");

    jogAbort_c: cover property (stat.start && stat.startOp == mcilk_pkg::OP_JOG
        ##[1:50] stat.abort);
    presetRun_c: cover property (stat.start && stat.startOp == mcilk_pkg::OP_PRESET);

endmodule

//--- hw/mcilk_top.sv
`timescale 1ns/1ns
`include "mcilk_cfg.svh"


module mcilk_top (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    // interface area word port
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [`MCILK_WORD_W-1:0] wrData,
    input wire logic [3:0] rdAddr,
    output logic [`MCILK_WORD_W-1:0] rdData,
    // interface refresh and axis command words
    input wire logic scan,
    input wire logic [`MCILK_AXES-1:0][`MCILK_WORD_W-1:0] axisCmd,
    input wire logic [`MCILK_AXES-1:0] presetReq,
    // motion engine completions
    input wire mcilk_pkg::mcilk_axis_done_t [`MCILK_AXES-1:0] axisDone,
    input wire logic [`MCILK_TASKS-1:0] progFinish,
    // axis status
    output mcilk_pkg::mcilk_axis_stat_t [`MCILK_AXES-1:0] axisStat,
    // task status
    output logic [`MCILK_TASKS-1:0] taskRun,
    output logic [`MCILK_TASKS-1:0] taskDone,
    output logic [`MCILK_TASKS-1:0] taskStart,
    output logic [`MCILK_TASKS-1:0][`MCILK_WORD_W-1:0] taskProgNum
);

    mcilk_pkg::mcilk_top_state_t q;
    mcilk_pkg::mcilk_top_state_t d;
    logic [`MCILK_TASKS-1:0] modeEdge;

    // ****************************************
    // word decode
    // ****************************************
    // index into the eight task words; bit 3 set means unmapped
    function automatic logic [3:0] wordIdx(input logic [3:0] a);
        logic [3:0] k;
        k = a - `MCILK_OFS_NUM0;
        if (a < `MCILK_OFS_NUM0 || a > `MCILK_OFS_LAST) begin
            k = 4'h8;
        end
        return k;
    endfunction

    // ****************************************
    // task sequencing
    // ****************************************
    always_comb begin
        logic [3:0] wi;
        logic [3:0] ri;
        logic [`MCILK_WORD_W-1:0] cw;
        logic [`MCILK_WORD_W-1:0] rise;
        logic [`MCILK_WORD_W-1:0] fall;
        wi = wordIdx(wrAddr);
        ri = wordIdx(rdAddr);
        cw = '0;
        rise = '0;
        fall = '0;
        d = q;
        d.start = '0;
        for (int k = 0; k < `MCILK_TASKS; k++) begin
            if (progFinish[k] && q.run[k]) begin
                d.run[k] = 1'b0;
                d.done[k] = 1'b1;
            end
            if (scan) begin
                cw = q.ctrlWord[k];
                rise = cw & ~q.prevCtrl[k];
                fall = ~cw & q.prevCtrl[k];
                d.prevCtrl[k] = cw;
                if (cw[`MCILK_BIT_READ]) begin
                    d.progNum[k] = q.numWord[k];
                end
                if (fall[`MCILK_BIT_MODE]) begin
                    d.run[k] = 1'b0;
                end else if (cw[`MCILK_BIT_MODE] && rise[`MCILK_BIT_CYCLE] && !q.run[k]) begin
                    d.run[k] = 1'b1;
                    d.done[k] = 1'b0;
                    d.start[k] = 1'b1;
                end else if (!cw[`MCILK_BIT_CYCLE]) begin
                    d.run[k] = 1'b0;
                end
            end
        end
        // host writes land after the scan decision so a scan sees the old word
        if (wrEn && !wi[3]) begin
            if (wi[0]) begin
                d.ctrlWord[wi[2:1]] = wrData;
            end else begin
                d.numWord[wi[2:1]] = wrData;
            end
        end
        if (ri[3]) begin
            d.rdData = '0;
        end else if (ri[0]) begin
            d.rdData = q.ctrlWord[ri[2:1]];
        end else begin
            d.rdData = q.numWord[ri[2:1]];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (en) begin
            q <= d;
        end
    end

    // ****************************************
    // per-axis interlocks
    // ****************************************
    // axis k follows the mode bit of task k
    always_comb begin
        for (int k = 0; k < `MCILK_TASKS; k++) begin
            modeEdge[k] = q.ctrlWord[k][`MCILK_BIT_MODE] != q.prevCtrl[k][`MCILK_BIT_MODE];
        end
    end

    generate
        for (genvar a = 0; a < `MCILK_AXES; a++) begin : gAxis
            mcilk_axis uAxis (
                .clk(clk),
                .resetn(resetn),
                .en(en),
                .scan(scan),
                .cmdWord(axisCmd[a]),
                .autoMode(q.ctrlWord[a][`MCILK_BIT_MODE]),
                .modeEdge(modeEdge[a]),
                .presetReq(presetReq[a]),
                .done(axisDone[a]),
                .stat(axisStat[a])
            );
        end
    endgenerate

    assign rdData = q.rdData;
    assign taskRun = q.run;
    assign taskDone = q.done;
    assign taskStart = q.start;
    assign taskProgNum = q.progNum;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    doneClearsRun_a: assert property (en && progFinish[0] && taskRun[0]
        && !(scan && q.ctrlWord[0][`MCILK_BIT_CYCLE] && !q.prevCtrl[0][`MCILK_BIT_CYCLE])
        |=> !taskRun[0])
        else $error("run flag survived completion");
    doneSets_a: assert property (en && progFinish[0] && taskRun[0]
        |=> taskDone[0])
        else $error("completed flag not set");
    cycleLowStops_a: assert property (en && scan && taskRun[0]
        && !q.ctrlWord[0][`MCILK_BIT_CYCLE] |=> !taskRun[0] [*2] or !en [*1])
        else $error("program kept running with cycle start low");
    numLatch_a: assert property (en && scan && q.ctrlWord[1][`MCILK_BIT_READ]
        |=> taskProgNum[1] == $past(q.numWord[1]))
        else $error("program number not latched");
    startNeedsAuto_a: assert property (taskStart[2] && $past(en)
        |-> $past(q.ctrlWord[2][`MCILK_BIT_MODE]) && taskRun[2] && !taskDone[2])
        else $error("program started outside automatic mode");
    modeFallStop_a: assert property (en && scan && q.prevCtrl[3][`MCILK_BIT_MODE]
        && !q.ctrlWord[3][`MCILK_BIT_MODE] |=> !taskRun[3])
        else $error("mode fall did not stop program");
    runNotDone_a: assert property (taskRun[0] && !$past(taskRun[0]) && $past(en)
        |-> !taskDone[0] && taskStart[0])
        else $error("run and completed rose together");
    ctrlWrite_a: assert property (en && wrEn && wrAddr == `MCILK_OFS_CTRL0
        |=> q.ctrlWord[0] == $past(wrData))
        else $error("control word write lost");
    unmappedRead_a: assert property (en && wordIdx(rdAddr) == 4'h8
        |=> rdData == `MCILK_RST_WORD)
        else $error("unmapped read not zero");
    axisIndep_a: assert property (en && scan && !axisStat[1].busy
        && !q.ctrlWord[1][`MCILK_BIT_MODE] && !axisCmd[1][`MCILK_BIT_DECEL]
        && !presetReq[1] && axisCmd[1][`MCILK_BIT_JOG]
        && !gAxis[1].uAxis.q.prevWord[`MCILK_BIT_JOG] && axisCmd[1][`MCILK_BIT_JOG:0] == 4'h8
        && !axisDone[1].opDone |=> axisStat[1].busy)
        else $error("idle axis refused a jog");

    progCycle_c: cover property (taskStart[0] ##[1:200] taskDone[0]);
    modeStop_c: cover property (taskRun[1] ##1 !taskRun[1] && !taskDone[1]);
    twoAxes_c: cover property (axisStat[0].busy && axisStat[1].busy);

endmodule

//--- dv/mcilk_host.sv
`timescale 1ns/1ns
module mcilk_host (
    // clock
    input wire logic clk,
    // word port toward the unit
    output logic wrEn,
    output logic [3:0] wrAddr,
    output logic [15:0] wrData,
    output logic scan
);
    // refresh every cycle, as a controller scan does
    initial begin
        wrEn = 1'b0;
        wrAddr = 4'h0;
        wrData = 16'h0000;
        scan = 1'b1;
    end
    // a released bus shows the inverse, so a stale word never looks valid
    task automatic put(input int a, input logic [15:0] d);
        @(negedge clk);
        wrEn = 1'b1;
        wrAddr = 4'(a);
        wrData = d;
        @(negedge clk);
        wrEn = 1'b0;
        wrData = ~d;
    endtask
    task automatic run_prog(input int t, input logic [15:0] n, input logic go);
        put(2 + 2 * t, n);
        put(3 + 2 * t, 16'h0082);
        put(3 + 2 * t, go ? 16'h0086 : 16'h0082);
    endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk;
    logic resetn;
    logic en = 1'b1;
    logic wrEn;
    logic scan;
    logic [3:0] wrAddr;
    logic [3:0] rdAddr = 4'h0;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic [3:0][15:0] axisCmd = '0;
    logic [3:0] presetReq = 4'h0;
    mcilk_pkg::mcilk_axis_done_t [3:0] axisDone = '0;
    logic [3:0] progFinish = 4'h0;
    mcilk_pkg::mcilk_axis_stat_t [3:0] axisStat;
    logic [3:0] taskRun;
    logic [3:0] taskDone;
    logic [3:0] taskStart;
    logic [3:0][15:0] taskProgNum;
    logic [15:0] bitw[4] = '{16'h0004, 16'h0020, 16'h0040, 16'h0100};
    mcilk_pkg::mcilk_op_t opw[4] = '{mcilk_pkg::OP_REFRET, mcilk_pkg::OP_FORCED,
        mcilk_pkg::OP_ABSINIT, mcilk_pkg::OP_HANDWHEEL};
    int n_mismatch = 0;
    int tests_run = 0;
    int expNum[$];
    int a;
    int b;
    bit h;

    mcilk_top u_mcilk_top (.clk(clk), .resetn(resetn), .en(en), .wrEn(wrEn),
        .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr), .rdData(rdData), .scan(scan),
        .axisCmd(axisCmd), .presetReq(presetReq), .axisDone(axisDone),
        .progFinish(progFinish), .axisStat(axisStat), .taskRun(taskRun),
        .taskDone(taskDone), .taskStart(taskStart), .taskProgNum(taskProgNum));
    mcilk_host u_mcilk_host (.clk(clk), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
        .scan(scan));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ********
    // checking
    // ********
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic sig(input int k, input int i);
        case (k)
            0: return axisStat[i].start;
            1: return axisStat[i].abort;
            2: return taskStart[i];
            3: return !axisStat[i].busy;
            default: return !taskRun[i];
        endcase
    endfunction
    // pulses are one cycle wide, so every falling edge is looked at
    task automatic look(input int k, input int i, output bit hit);
        hit = 1'b0;
        for (int n = 0; n < 6 && !hit; n++) begin
            @(negedge clk);
            hit = (sig(k, i) === 1'b1);
        end
    endtask
    task automatic need(input int k, input int i);
        bit hit;
        look(k, i, hit);
        cmp_word(32'h0000_0001, {31'h0000_0000, hit});
        if (!hit) begin
            wrap_up();
        end
    endtask
    task automatic start_is(input int x, input mcilk_pkg::mcilk_op_t op);
        need(0, x);
        cmp_word(32'(op), 32'(axisStat[x].startOp));
        cmp_word(32'h0000_0001, 32'(axisStat[x].busy));
    endtask
    task automatic none(input int x);
        look(0, x, h);
        cmp_word(32'h0000_0000, 32'(h));
    endtask
    task automatic cmd(input int x, input logic [15:0] w);
        @(negedge clk);
        axisCmd[x] = w;
    endtask
    task automatic fin(input int x, input logic [2:0] d);
        @(negedge clk);
        axisDone[x] = d;
        @(negedge clk);
        axisDone[x] = 3'b000;
    endtask

    // ********
    // stimulus
    // ********
    initial begin
        repeat (40000) @(negedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        cmp_word(32'h0000_0000, {taskRun, axisStat});
        resetn = 1'b1;
        a = $urandom(32'h0000_5288) % 4;
        b = (a + 1) % 4;
        cmd(a, 16'h0001);
        none(a);
        cmd(a, 16'h0009);
        none(a);
        cmd(a, 16'h0019);
        start_is(a, mcilk_pkg::OP_ERRRST);
        fin(a, 3'b010);
        need(3, a);
        cmd(a, 16'h0000);
        cmd(a, 16'h0008);
        start_is(a, mcilk_pkg::OP_JOG);
        cmd(b, 16'h0200);
        start_is(b, mcilk_pkg::OP_LOCK);
        cmd(a, 16'h0208);
        none(a);
        cmp_word(32'h0000_0001, 32'(axisStat[a].busy));
        cmd(b, 16'h0000);
        none(b);
        cmp_word(32'h0000_0001, 32'(axisStat[b].busy));
        cmd(a, 16'h0200);
        need(1, a);
        need(3, a);
        fin(b, 3'b100);
        need(3, b);
        cmd(a, 16'h0222);
        start_is(a, mcilk_pkg::OP_ORIGIN);
        cmd(a, 16'h0223);
        start_is(a, mcilk_pkg::OP_DECEL);
        fin(a, 3'b100);
        need(3, a);
        cmd(a, 16'h0000);
        cmd(b, 16'h0200);
        start_is(b, mcilk_pkg::OP_LOCK);
        presetReq[b] = 1'b1;
        @(negedge clk);
        presetReq[b] = 1'b0;
        none(b);
        cmd(b, 16'h0600);
        start_is(b, mcilk_pkg::OP_RELEASE);
        fin(b, 3'b101);
        need(3, b);
        cmd(b, 16'h0000);
        presetReq[b] = 1'b1;
        start_is(b, mcilk_pkg::OP_PRESET);
        presetReq[b] = 1'b0;
        fin(b, 3'b100);
        need(3, b);
        for (int i = 0; i < 4; i++) begin
            cmd(b, bitw[i]);
            start_is(b, opw[i]);
            fin(b, 3'b100);
            need(3, b);
            cmd(b, 16'h0000);
        end
        for (int t = 0; t < 4; t++) begin
            expNum.push_back($urandom % 1000);
            u_mcilk_host.run_prog(t, 16'(expNum[t]), 1'b1);
            need(2, t);
            cmp_word(32'h0000_0001, 32'(taskRun[t]));
            if (t % 2 == 0) begin
                progFinish[t] = 1'b1;
                @(negedge clk);
                progFinish[t] = 1'b0;
                need(4, t);
                cmp_word(32'h0000_0001, 32'(taskDone[t]));
            end else begin
                u_mcilk_host.run_prog(t, 16'(expNum[t]), 1'b0);
                need(4, t);
            end
        end
        cmd(1, 16'h0018);
        start_is(1, mcilk_pkg::OP_ERRRST);
        fin(1, 3'b010);
        u_mcilk_host.run_prog(0, 16'(expNum[0]), 1'b1);
        need(2, 0);
        u_mcilk_host.put(3, 16'h0000);
        need(4, 0);
        for (int t = 0; t < 4; t++) begin
            cmp_word(32'(expNum[t]), 32'(taskProgNum[t]));
        end
        // a write while the enable is low must not land
        en = 1'b0;
        u_mcilk_host.put(5, 16'h0000);
        en = 1'b1;
        rdAddr = 4'h5;
        repeat (2) @(negedge clk);
        cmp_word(32'h0000_0082, 32'(rdData));
        rdAddr = 4'hf;
        repeat (2) @(negedge clk);
        cmp_word(32'h0000_0000, 32'(rdData));
        wrap_up();
    end
endmodule
